// ### include/ldr_pkg.sv
// ldr_pkg: constants and types of the look-up-table distributed memory cell.
// assumes: apb slave on pclk at 125 MHz, registers one aligned 32-bit word each.
package ldr_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned LDR_CLK_PERIOD_NS = 8;
  // longest time the write clock may rest in its post-edge phase, 1 ms
  localparam int unsigned LDR_T_STALL_NS = 1000000;
  // longest time, so rounded down
  localparam int unsigned LDR_STALL_CYCLES = LDR_T_STALL_NS / LDR_CLK_PERIOD_NS;
  localparam int unsigned LDR_STALL_CNT_W = 17;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [7:0] LDR_OFS_CTRL = 8'h00;
  localparam logic [7:0] LDR_OFS_HFUNC = 8'h04;
  localparam logic [7:0] LDR_OFS_STATUS = 8'h08;
  localparam logic [7:0] LDR_OFS_CONTENT = 8'h0c;

  // ==========================================================================
  // field positions
  localparam int unsigned LDR_CTRL_MODE_LSB = 0;
  localparam int unsigned LDR_CTRL_LEVEL_BIT = 2;
  localparam int unsigned LDR_CTRL_WFALL_BIT = 3;
  localparam int unsigned LDR_CTRL_FFALL_BIT = 4;
  localparam int unsigned LDR_CTRL_SRCX_LSB = 5;
  localparam int unsigned LDR_CTRL_SRCY_LSB = 7;
  localparam int unsigned LDR_STAT_STALL_BIT = 8;
  localparam int unsigned LDR_CONTENT_B_LSB = 16;

  // ==========================================================================
  // reset values
  localparam logic [7:0] LDR_HFUNC_RST = 8'h00;
  localparam logic [15:0] LDR_TABLE_INIT = 16'h0000;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {LDR_M16X2, LDR_M16X1, LDR_M32X1, LDR_MDUAL} ldr_mode_e;
  typedef enum logic [1:0] {LDR_SRC_F, LDR_SRC_G, LDR_SRC_H, LDR_SRC_D0} ldr_src_e;

  typedef struct packed {
    logic [15:0] cells;
  } ldr_table_s;

  typedef struct packed {
    ldr_mode_e mode;
    logic level_sel;
    logic wfall_sel;
    logic ffall_sel;
    ldr_src_e src_x;
    ldr_src_e src_y;
    logic [7:0] hfunc;
    logic wclk_prev;
    logic wr_pulse;
    logic [3:0] lat_a_addr;
    logic [3:0] lat_b_addr;
    logic lat_d0;
    logic lat_d1;
    logic ff_x;
    logic ff_y;
    logic [LDR_STALL_CNT_W-1:0] stall_cnt;
    logic stall_seen;
    logic [31:0] rdata;
  } ldr_top_s;

endpackage

// ### logic/ldr_table16.sv
// ldr_table16: one sixteen-cell look-up table used as memory, one write, one read port.
// assumes: write strobe, address and data come from logic on pclk.
`timescale 1ns/1ns
module ldr_table16
  import ldr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic wr_data,
  input wire logic [3:0] rd_addr,
  output logic rd_data,
  output logic [15:0] cells
);

  // ==========================================================================
  // state
  ldr_table_s st_reg;
  ldr_table_s st_next;

  always_comb begin
    st_next = st_reg;
    if (wr_en) begin
      st_next.cells[wr_addr] = wr_data;
    end
  end

  // presetn stands for configuration; the set/reset net never reaches here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{cells: LDR_TABLE_INIT};
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // read path: plain mux, no clock in the way
  assign rd_data = st_reg.cells[rd_addr];
  assign cells = st_reg.cells;

  // ==========================================================================
  // checks
  a_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en |=> (cells[$past(wr_addr)] == $past(wr_data)) && (rd_addr != $past(wr_addr)
      || rd_data == $past(wr_data)))
    else $error("table write did not land");

  a_idle_holds: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_en |=> $stable(cells))
    else $error("table changed without write strobe");

endmodule

// ### logic/ldr_cell_ram.sv
// ldr_cell_ram: logic cell whose two look-up tables serve as small read/write memory.
// assumes: user-side ports come from logic on pclk; registers over apb, zero wait.
`timescale 1ns/1ns
module ldr_cell_ram
  import ldr_pkg::*;
#(
  parameter int unsigned STALL_LIMIT = LDR_STALL_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] lut_a_addr,
  input wire logic [3:0] lut_b_addr,
  input wire logic [3:0] secondary_read_addr,
  input wire logic ctrl_in_direct,
  input wire logic ctrl_in_one,
  input wire logic ctrl_in_setreset,
  input wire logic write_clk,
  input wire logic global_set_reset_net,
  output logic primary_read_out,
  output logic secondary_read_out,
  output logic h_func_out,
  output logic cell_ff_x_q,
  output logic cell_ff_y_q
);

  // ==========================================================================
  // declarations
  ldr_top_s st_reg;
  ldr_top_s st_next;
  logic data_in_a;
  logic data_in_b;
  logic write_en;
  logic wclk_rise;
  logic wclk_fall;
  logic wr_edge;
  logic ff_edge;
  logic level_mode;
  logic post_edge_phase;
  logic apb_wr;
  logic apb_setup;
  logic mapped;
  logic wr_strobe;
  logic [3:0] wr_addr;
  logic [3:0] wr_addr_b;
  logic wr_d0;
  logic wr_d1;
  logic tab_a_we;
  logic tab_b_we;
  logic tab_b_din;
  logic [3:0] tab_b_raddr;
  logic rd_a;
  logic rd_b;
  logic [15:0] tab_a_cells;
  logic [15:0] tab_b_cells;

  // ==========================================================================
  // control input remap in memory mode
  assign data_in_a = ctrl_in_direct;
  assign data_in_b = ctrl_in_one;
  assign write_en = ctrl_in_setreset;

  // ==========================================================================
  // clock edges seen on pclk; write_clk comes from logic on pclk
  always_comb begin
    wclk_rise = write_clk & ~st_reg.wclk_prev;
    wclk_fall = ~write_clk & st_reg.wclk_prev;
    wr_edge = st_reg.wfall_sel ? wclk_fall : wclk_rise;
    ff_edge = st_reg.ffall_sel ? wclk_fall : wclk_rise;
    level_mode = st_reg.level_sel & (st_reg.mode != LDR_MDUAL);
    post_edge_phase = (write_clk != st_reg.wfall_sel);
  end

  // ==========================================================================
  // write path: edge mode uses latched values, level mode the live ones
  always_comb begin
    if (level_mode) begin
      wr_strobe = write_en;
      wr_addr = lut_a_addr;
      wr_addr_b = lut_b_addr;
      wr_d0 = data_in_a;
      wr_d1 = data_in_b;
    end else begin
      wr_strobe = st_reg.wr_pulse;
      wr_addr = st_reg.lat_a_addr;
      wr_addr_b = st_reg.lat_b_addr;
      wr_d0 = st_reg.lat_d0;
      wr_d1 = st_reg.lat_d1;
    end
    tab_a_we = 1'b0;
    tab_b_we = 1'b0;
    tab_b_din = wr_d1;
    tab_b_raddr = lut_b_addr;
    case (st_reg.mode)
      LDR_M16X2: begin
        tab_a_we = wr_strobe;
        tab_b_we = wr_strobe;
      end
      LDR_M16X1: begin
        tab_a_we = wr_strobe;
      end
      LDR_M32X1: begin
        // fifth bit rides on the second data input, latched with the rest
        tab_a_we = wr_strobe & ~wr_d1;
        tab_b_we = wr_strobe & wr_d1;
        tab_b_din = wr_d0;
        wr_addr_b = wr_addr;
        tab_b_raddr = lut_a_addr;
      end
      LDR_MDUAL: begin
        tab_a_we = wr_strobe;
        tab_b_we = wr_strobe;
        tab_b_din = wr_d0;
        wr_addr_b = wr_addr;
        tab_b_raddr = secondary_read_addr;
      end
      default: begin
        tab_a_we = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // the two tables
  ldr_table16 u_tab_a (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(tab_a_we),
    .wr_addr(wr_addr),
    .wr_data(wr_d0),
    .rd_addr(lut_a_addr),
    .rd_data(rd_a),
    .cells(tab_a_cells)
  );

  ldr_table16 u_tab_b (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(tab_b_we),
    .wr_addr(wr_addr_b),
    .wr_data(tab_b_din),
    .rd_addr(tab_b_raddr),
    .rd_data(rd_b),
    .cells(tab_b_cells)
  );

  // ==========================================================================
  // read outputs, combinational in every mode
  always_comb begin
    if (st_reg.mode == LDR_M32X1) begin
      primary_read_out = data_in_b ? rd_b : rd_a;
    end else begin
      primary_read_out = rd_a;
    end
    secondary_read_out = rd_b;
    h_func_out = st_reg.hfunc[{data_in_b, rd_b, rd_a}];
  end

  assign cell_ff_x_q = st_reg.ff_x;
  assign cell_ff_y_q = st_reg.ff_y;

  // ==========================================================================
  // apb decode; zero wait, read data captured in the setup cycle
  always_comb begin
    apb_setup = psel & ~penable;
    apb_wr = psel & penable & pwrite;
    mapped = (paddr == LDR_OFS_CTRL) || (paddr == LDR_OFS_HFUNC)
      || (paddr == LDR_OFS_STATUS) || (paddr == LDR_OFS_CONTENT);
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = st_reg.rdata;

  // flip-flop input select: primary, secondary, third function or direct input
  function automatic logic ff_pick(input ldr_src_e src, input logic f, input logic g,
                                   input logic h, input logic d0);
    case (src)
      LDR_SRC_F: ff_pick = f;
      LDR_SRC_G: ff_pick = g;
      LDR_SRC_H: ff_pick = h;
      default: ff_pick = d0;
    endcase
  endfunction

  // ==========================================================================
  // next state
  always_comb begin
    st_next = st_reg;
    st_next.wclk_prev = write_clk;
    // edge: sample address, data and enable; an active edge with enable high starts the pulse
    st_next.wr_pulse = wr_edge & write_en;
    if (wr_edge) begin
      st_next.lat_a_addr = lut_a_addr;
      st_next.lat_b_addr = lut_b_addr;
      st_next.lat_d0 = data_in_a;
      st_next.lat_d1 = data_in_b;
    end
    // cell flip-flops; set/reset net clears them but never the tables
    if (global_set_reset_net) begin
      st_next.ff_x = 1'b0;
      st_next.ff_y = 1'b0;
    end else if (ff_edge) begin
      st_next.ff_x = ff_pick(st_reg.src_x, primary_read_out, secondary_read_out,
                             h_func_out, data_in_a);
      st_next.ff_y = ff_pick(st_reg.src_y, primary_read_out, secondary_read_out,
                             h_func_out, data_in_a);
    end
    // watch for a write clock parked after its active edge; a status hint only
    if (post_edge_phase) begin
      if (st_reg.stall_cnt != LDR_STALL_CNT_W'(STALL_LIMIT)) begin
        st_next.stall_cnt = st_reg.stall_cnt + 1'b1;
      end
    end else begin
      st_next.stall_cnt = '0;
    end
    if (apb_wr && paddr == LDR_OFS_STATUS && pwdata[LDR_STAT_STALL_BIT]) begin
      st_next.stall_seen = 1'b0;
    end
    // set wins over a clear in the same cycle
    if (post_edge_phase && st_reg.stall_cnt == LDR_STALL_CNT_W'(STALL_LIMIT - 1)) begin
      st_next.stall_seen = 1'b1;
    end
    if (apb_wr && paddr == LDR_OFS_CTRL) begin
      st_next.mode = ldr_mode_e'(pwdata[LDR_CTRL_MODE_LSB +: 2]);
      st_next.level_sel = pwdata[LDR_CTRL_LEVEL_BIT];
      st_next.wfall_sel = pwdata[LDR_CTRL_WFALL_BIT];
      st_next.ffall_sel = pwdata[LDR_CTRL_FFALL_BIT];
      st_next.src_x = ldr_src_e'(pwdata[LDR_CTRL_SRCX_LSB +: 2]);
      st_next.src_y = ldr_src_e'(pwdata[LDR_CTRL_SRCY_LSB +: 2]);
    end
    if (apb_wr && paddr == LDR_OFS_HFUNC) begin
      st_next.hfunc = pwdata[7:0];
    end
    if (apb_setup) begin
      st_next.rdata = '0;
      case (paddr)
        LDR_OFS_CTRL: begin
          st_next.rdata[LDR_CTRL_MODE_LSB +: 2] = st_reg.mode;
          st_next.rdata[LDR_CTRL_LEVEL_BIT] = st_reg.level_sel;
          st_next.rdata[LDR_CTRL_WFALL_BIT] = st_reg.wfall_sel;
          st_next.rdata[LDR_CTRL_FFALL_BIT] = st_reg.ffall_sel;
          st_next.rdata[LDR_CTRL_SRCX_LSB +: 2] = st_reg.src_x;
          st_next.rdata[LDR_CTRL_SRCY_LSB +: 2] = st_reg.src_y;
        end
        LDR_OFS_HFUNC: begin
          st_next.rdata[7:0] = st_reg.hfunc;
        end
        LDR_OFS_STATUS: begin
          st_next.rdata[4:0] = {st_reg.ff_y, st_reg.ff_x, h_func_out,
                                secondary_read_out, primary_read_out};
          st_next.rdata[5] = level_mode;
          st_next.rdata[LDR_STAT_STALL_BIT] = st_reg.stall_seen;
        end
        LDR_OFS_CONTENT: begin
          st_next.rdata[15:0] = tab_a_cells;
          st_next.rdata[LDR_CONTENT_B_LSB +: 16] = tab_b_cells;
        end
        default: begin
          st_next.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{mode: LDR_M16X2, src_x: LDR_SRC_F, src_y: LDR_SRC_F,
                  hfunc: LDR_HFUNC_RST, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_edge_write_lands: assert property (
    (!level_mode && wr_edge && write_en && st_reg.mode == LDR_M16X2 && !apb_wr)
      |-> ##2 tab_a_cells[$past(lut_a_addr, 2)] == $past(data_in_a, 2))
    else $error("edge write missing two cycles after active edge");

  a_no_stray_write: assert property (
    (!level_mode && !st_reg.wr_pulse) |=> $stable(tab_a_cells) && $stable(tab_b_cells))
    else $error("table changed without internal write pulse");

  a_pulse_single: assert property (
    (wr_edge && write_en) |=> st_reg.wr_pulse ##1 !st_reg.wr_pulse)
    else $error("internal write pulse not one cycle after edge");

  a_dual_edge_only: assert property (
    (st_reg.mode == LDR_MDUAL && !st_reg.wr_pulse)
      |=> $stable(tab_a_cells) && $stable(tab_b_cells))
    else $error("dual-port mode wrote without internal pulse");

  a_dual_read_port: assert property (
    (st_reg.mode == LDR_MDUAL) |-> secondary_read_out == tab_b_cells[secondary_read_addr])
    else $error("secondary output not at secondary address");

  a_primary_read: assert property (
    (st_reg.mode != LDR_M32X1) |-> primary_read_out == tab_a_cells[lut_a_addr])
    else $error("primary output not at primary address");

  a_fifth_addr_bit: assert property (
    (st_reg.mode == LDR_M32X1) |-> primary_read_out
      == (data_in_b ? tab_b_cells[lut_a_addr] : tab_a_cells[lut_a_addr]))
    else $error("fifth address bit selects wrong table");

  a_level_write: assert property (
    (level_mode && write_en && st_reg.mode == LDR_M16X2 && !apb_wr)
      |=> tab_a_cells[$past(lut_a_addr)] == $past(data_in_a))
    else $error("level write did not store data");

  a_ff_capture: assert property (
    (ff_edge && !global_set_reset_net && st_reg.src_x == LDR_SRC_H && !apb_wr)
      |=> cell_ff_x_q == $past(h_func_out))
    else $error("flip-flop missed its source on its edge");

  a_gsr_spares_ram: assert property (
    (global_set_reset_net && !tab_a_we && !tab_b_we)
      |=> !cell_ff_x_q && !cell_ff_y_q && $stable(tab_a_cells) && $stable(tab_b_cells))
    else $error("set/reset net handled wrongly");

  c_dual_write: cover property (st_reg.mode == LDR_MDUAL && st_reg.wr_pulse);
  c_level_write: cover property (level_mode && write_en);
  c_upper_write: cover property (st_reg.mode == LDR_M32X1 && tab_b_we);
  c_stall_flag: cover property (!st_reg.stall_seen ##1 st_reg.stall_seen);

endmodule

// ### tb/ldr_user_model.sv
// ldr_user_model: user logic that drives the memory cell's address, data and write clock.
// assumes: the bench calls its tasks; every drive follows a rising pclk edge.
`timescale 1ns/1ns
module ldr_user_model (
  input wire logic pclk,
  output logic [3:0] lut_a_addr,
  output logic [3:0] lut_b_addr,
  output logic [3:0] secondary_read_addr,
  output logic ctrl_in_direct,
  output logic ctrl_in_one,
  output logic ctrl_in_setreset,
  output logic write_clk
);
  logic idle_lvl;

  initial begin
    idle_lvl = 1'b0;
    {lut_a_addr, lut_b_addr, secondary_read_addr} = 12'h000;
    {ctrl_in_direct, ctrl_in_one, ctrl_in_setreset, write_clk} = 4'h0;
  end

  // ==========
  // edge write, request held across the detecting edges
  task automatic edge_wr(input logic [3:0] a, input logic [3:0] b, input logic d0,
    input logic d1, input logic en);
    @(posedge pclk);
    lut_a_addr <= a;
    lut_b_addr <= b;
    ctrl_in_direct <= d0;
    ctrl_in_one <= d1;
    ctrl_in_setreset <= en;
    write_clk <= ~idle_lvl;
    repeat (2) @(posedge pclk);
    write_clk <= idle_lvl;
    ctrl_in_setreset <= 1'b0;
    // released data turns over, so stale data cannot pass for stored data
    ctrl_in_direct <= ~d0;
    repeat (2) @(posedge pclk);
  endtask

  // ==========
  // level write, one-cycle strobe inside a settled address
  task automatic level_wr(input logic [3:0] a, input logic [3:0] b, input logic d0,
    input logic d1);
    @(posedge pclk);
    lut_a_addr <= a;
    lut_b_addr <= b;
    ctrl_in_direct <= d0;
    ctrl_in_one <= d1;
    @(posedge pclk);
    ctrl_in_setreset <= 1'b1;
    @(posedge pclk);
    ctrl_in_setreset <= 1'b0;
    @(posedge pclk);
    ctrl_in_direct <= ~d0;
    @(posedge pclk);
  endtask

  // ==========
  // read addressing, outputs settled on return
  task automatic point(input logic [3:0] a, input logic [3:0] b, input logic [3:0] dp,
    input logic d1);
    @(posedge pclk);
    lut_a_addr <= a;
    lut_b_addr <= b;
    secondary_read_addr <= dp;
    ctrl_in_one <= d1;
    @(posedge pclk);
    #1;
  endtask

  task automatic set_idle(input logic l);
    @(posedge pclk);
    idle_lvl = l;
    write_clk <= l;
  endtask

  // held in the post-edge phase on purpose, only to provoke the stall flag
  task automatic stall(input int n);
    @(posedge pclk);
    write_clk <= ~idle_lvl;
    repeat (n) @(posedge pclk);
    write_clk <= idle_lvl;
  endtask
endmodule

// ### tb/test_lut_distributed_ram.sv
// test_lut_distributed_ram: self-checking bench of the look-up-table memory cell.
// assumes: ldr_pkg compiled first; registers zero-wait apb; short stall limit.
`timescale 1ns/1ns
module test_lut_distributed_ram
  import ldr_pkg::*;
;
  localparam int unsigned STALL = 20;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, global_set_reset_net;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] lut_a_addr, lut_b_addr, secondary_read_addr;
  logic ctrl_in_direct, ctrl_in_one, ctrl_in_setreset, write_clk;
  logic primary_read_out, secondary_read_out, h_func_out, cell_ff_x_q, cell_ff_y_q;
  int miscompares = 0;
  int samples_checked = 0;

  always #4 pclk = ~pclk;

  ldr_cell_ram #(.STALL_LIMIT(STALL)) i_dut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lut_a_addr(lut_a_addr),
    .lut_b_addr(lut_b_addr), .secondary_read_addr(secondary_read_addr),
    .ctrl_in_direct(ctrl_in_direct), .ctrl_in_one(ctrl_in_one),
    .ctrl_in_setreset(ctrl_in_setreset), .write_clk(write_clk),
    .global_set_reset_net(global_set_reset_net), .primary_read_out(primary_read_out),
    .secondary_read_out(secondary_read_out), .h_func_out(h_func_out),
    .cell_ff_x_q(cell_ff_x_q), .cell_ff_y_q(cell_ff_y_q));

  ldr_user_model i_user (.pclk(pclk), .lut_a_addr(lut_a_addr), .lut_b_addr(lut_b_addr),
    .secondary_read_addr(secondary_read_addr), .ctrl_in_direct(ctrl_in_direct),
    .ctrl_in_one(ctrl_in_one), .ctrl_in_setreset(ctrl_in_setreset), .write_clk(write_clk));

  // ==========
  // shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // one apb transfer; waits for pready, watchdog bounds the wait
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 32'h0, r, e);
    chk(r & m, x, "register read");
  endtask

  task automatic pt(input logic [3:0] a, input logic [3:0] b, input logic [3:0] dp,
    input logic d1, input logic [1:0] m, input logic [1:0] x);
    i_user.point(a, b, dp, d1);
    chk({30'h0, {primary_read_out, secondary_read_out} & m}, {30'h0, x}, "read ports");
  endtask

  // ==========
  // scenarios
  task automatic t_reset;
    logic [31:0] r;
    logic e;
    rd(LDR_OFS_CTRL, ALL, 32'h0);
    rd(LDR_OFS_HFUNC, ALL, 32'h0);
    rd(LDR_OFS_STATUS, ALL, 32'h0);
    rd(LDR_OFS_CONTENT, ALL, 32'h0);
    apb(8'h10, 1'b1, ALL, r, e);
    chk({31'h0, e}, 32'h1, "unmapped write error");
    apb(8'h10, 1'b0, 32'h0, r, e);
    chk({31'h0, e}, 32'h1, "unmapped read error");
    chk(r, 32'h0, "unmapped read data");
    $display("test reset done");
  endtask

  task automatic t_edge;
    wr(LDR_OFS_CTRL, 32'h0);
    i_user.edge_wr(4'h5, 4'h9, 1'b1, 1'b1, 1'b1);
    pt(4'h5, 4'h9, 4'h0, 1'b1, 2'b11, 2'b11);
    i_user.edge_wr(4'h6, 4'ha, 1'b1, 1'b1, 1'b0);
    rd(LDR_OFS_CONTENT, ALL, 32'h0200_0020);
    $display("test edge done");
  endtask

  task automatic t_wide;
    wr(LDR_OFS_CTRL, 32'h2);
    i_user.edge_wr(4'h3, 4'h0, 1'b1, 1'b1, 1'b1);
    i_user.edge_wr(4'hc, 4'h0, 1'b1, 1'b0, 1'b1);
    pt(4'h3, 4'h0, 4'h0, 1'b1, 2'b10, 2'b10);
    pt(4'h3, 4'h0, 4'h0, 1'b0, 2'b10, 2'b00);
    pt(4'hc, 4'h0, 4'h0, 1'b0, 2'b10, 2'b10);
    rd(LDR_OFS_CONTENT, ALL, 32'h0208_1020);
    $display("test wide done");
  endtask

  task automatic t_dual;
    wr(LDR_OFS_CTRL, 32'h7);
    rd(LDR_OFS_STATUS, 32'h20, 32'h0);
    i_user.point(4'hb, 4'h0, 4'hb, 1'b0);
    i_user.edge_wr(4'hb, 4'h0, 1'b1, 1'b0, 1'b1);
    pt(4'hb, 4'h0, 4'hb, 1'b0, 2'b11, 2'b11);
    pt(4'h0, 4'h0, 4'hb, 1'b0, 2'b11, 2'b01);
    pt(4'hb, 4'h0, 4'h0, 1'b0, 2'b11, 2'b10);
    i_user.level_wr(4'hd, 4'hd, 1'b1, 1'b1);
    rd(LDR_OFS_CONTENT, ALL, 32'h0a08_1820);
    $display("test dual done");
  endtask

  task automatic t_level;
    wr(LDR_OFS_CTRL, 32'h4);
    rd(LDR_OFS_STATUS, 32'h20, 32'h20);
    i_user.level_wr(4'he, 4'hf, 1'b1, 1'b1);
    rd(LDR_OFS_CONTENT, ALL, 32'h8a08_5820);
    $display("test level done");
  endtask

  task automatic t_fall;
    wr(LDR_OFS_CTRL, 32'h8);
    i_user.set_idle(1'b1);
    i_user.edge_wr(4'h1, 4'h2, 1'b1, 1'b1, 1'b1);
    rd(LDR_OFS_CONTENT, ALL, 32'h8a0c_5822);
    wr(LDR_OFS_CTRL, 32'h0);
    i_user.set_idle(1'b0);
    $display("test falling done");
  endtask

  task automatic t_stall;
    i_user.stall(STALL - 4);
    rd(LDR_OFS_STATUS, 32'h100, 32'h0);
    i_user.stall(STALL + 4);
    rd(LDR_OFS_STATUS, 32'h100, 32'h100);
    wr(LDR_OFS_STATUS, 32'h100);
    rd(LDR_OFS_STATUS, 32'h100, 32'h0);
    $display("test stall done");
  endtask

  task automatic t_hff;
    wr(LDR_OFS_HFUNC, 32'h80);
    wr(LDR_OFS_CTRL, 32'h1c0);
    i_user.point(4'h5, 4'h9, 4'h0, 1'b1);
    chk({31'h0, h_func_out}, 32'h1, "third function high");
    i_user.point(4'h5, 4'h9, 4'h0, 1'b0);
    chk({31'h0, h_func_out}, 32'h0, "third function low");
    i_user.edge_wr(4'h5, 4'h9, 1'b1, 1'b1, 1'b0);
    chk({30'h0, cell_ff_x_q, cell_ff_y_q}, 32'h3, "flip-flop capture");
    @(posedge pclk);
    global_set_reset_net <= 1'b1;
    @(posedge pclk);
    global_set_reset_net <= 1'b0;
    @(posedge pclk);
    #1;
    chk({30'h0, cell_ff_x_q, cell_ff_y_q}, 32'h0, "flip-flops cleared");
    rd(LDR_OFS_CONTENT, ALL, 32'h8a0c_5822);
    wr(LDR_OFS_CTRL, 32'h1b0);
    i_user.edge_wr(4'h0, 4'h9, 1'b1, 1'b0, 1'b0);
    chk({30'h0, cell_ff_x_q, cell_ff_y_q}, 32'h2, "falling flip-flop clock");
    $display("test function done");
  endtask

  // ==========
  // verdict
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, global_set_reset_net} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_edge;
    t_wide;
    t_dual;
    t_level;
    t_fall;
    t_stall;
    t_hff;
    close_out;
  end

  // whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    close_out;
  end
endmodule
